/* File: hdl/mio_pad_drv.sv */
// Pad driver selection: push-pull or sink open-drain per bit, with an enable.
// Assumes the caller registers the outputs before they reach the pins.
`timescale 1ns/1ps
module mio_pad_drv
#(
   parameter int W = 8
)
(
   input wire logic [W-1:0] value,
   input wire logic [W-1:0] push_pull,
   input wire logic [W-1:0] en,
   output logic [W-1:0] out,
   output logic [W-1:0] oe
);
   initial
   begin
      if (W < 1)
      begin
         $error("mio_pad_drv width must be at least one");
      end
   end

   // Open-drain bits only ever pull low; a one simply releases the pin.
   assign out = value & push_pull;
   assign oe = en & (push_pull | ~value);
endmodule

/* File: hdl/mio_params.svh */
// Constants of the multifunction I/O ports: register indices, reset values, control bits.
// Assumes word-addressed Avalon-MM access where byte address = 4 * register index.
// Operation
// - Reset sets port 0 output latch to all ones and driver select to zero.
// - Port 0 driver select bit zero gives sink open-drain, one gives push-pull.
// - Port 0 latch register reads latch; separate read-only register reads live pins.
// - Port 0 serial or UART output pins drive peripheral only while latch is one.
// - Port 0 routes interrupts to 0,3,7, UART to 1,2, serial to 4,5,6.
// - Port 1 direction zero is input, one output; direction and latch reset zero.
// - Port 1 data read gives latch for outputs, pin level for inputs.
// - Read-modify-write on port 1 may copy pin levels into input-mode latch bits.
// - Port 1 carries timer, divider, pulse, PWM outputs and interrupt on bit 5.
// - Port 2 is three bits wide with latch reset to all ones.
// - Dual-clock mode gives port 2 bits 1 and 2 to the slow crystal.
// - A falling edge on port 2 bit 0 flags the external interrupt.
// - Port 2 reads return bits 7 to 3 as zero; only low three carry data.
// - In stop mode port 2 bit 0 floats regardless of output enable.
// - Port 2 latch and pin levels are read at separate addresses.
// - Pins sample at the request cycle; latches update at the acknowledge edge.
`ifndef MIO_PARAMS_SVH
`define MIO_PARAMS_SVH

`define MIO_IDX_P0_LATCH 6'h00
`define MIO_IDX_P1_LATCH 6'h01
`define MIO_IDX_P2_LATCH 6'h02
`define MIO_IDX_P0_DRV 6'h08
`define MIO_IDX_P1_DIR 6'h09
`define MIO_IDX_P0_PIN 6'h0b
`define MIO_IDX_P2_PIN 6'h0c
`define MIO_IDX_CTRL 6'h10

`define MIO_RST_P0_LATCH 8'hff
`define MIO_RST_P0_DRV 8'h00
`define MIO_RST_P1_LATCH 8'h00
`define MIO_RST_P1_DIR 8'h00
`define MIO_RST_P2_LATCH 3'h7
`define MIO_RST_CTRL 3'h4

`define MIO_CTRL_DUAL 0
`define MIO_CTRL_STOP 1
`define MIO_CTRL_PIN_OUTPUT_ENABLE 2

`endif

/* File: hdl/mio_pkg.sv */
// Types shared by the multifunction I/O port block.
// Assumes the constants header is included by each user.
package mio_pkg;

   typedef struct packed {
      logic [7:0] p0_latch;
      logic [7:0] p0_drv;
      logic [7:0] p1_latch;
      logic [7:0] p1_dir;
      logic [2:0] p2_latch;
      logic [2:0] ctrl;
      logic waitrequest;
      logic [31:0] rdata;
      logic [7:0] p0_out;
      logic [7:0] p0_oe;
      logic [7:0] p1_out;
      logic [7:0] p1_oe;
      logic [2:0] p2_out;
      logic [2:0] p2_oe;
      logic p20_prev;
      logic p20_fall;
   } mio_state_t;

endpackage

/* File: hdl/mio_ports.sv */
// Three multifunction pin ports with Avalon-MM register access.
// Assumes peripheral outputs idle high and the external wire resolves OUT/OE pairs.
`timescale 1ns/1ps
`include "mio_params.svh"
module mio_ports
#(
   parameter int ADDR_W = 8
)
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic [ADDR_W-1:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic [7:0] P0_IN,
   output logic [7:0] P0_OUT,
   output logic [7:0] P0_OE,
   input wire logic [7:0] P1_IN,
   output logic [7:0] P1_OUT,
   output logic [7:0] P1_OE,
   input wire logic [2:0] P2_IN,
   output logic [2:0] P2_OUT,
   output logic [2:0] P2_OE,
   input wire logic UART_TX_PIN,
   input wire logic SERIAL_OUT_PIN,
   input wire logic SERIAL_CLOCK_PIN,
   input wire logic [7:0] P1_FN_OUT,
   output logic EXT_IRQ_A,
   output logic EXT_IRQ_B,
   output logic EXT_IRQ_C,
   output logic EXT_IRQ_D,
   output logic UART_RX_PIN,
   output logic SERIAL_IN_PIN,
   output logic SERIAL_CLOCK_IN,
   output logic TIMER_IN_A,
   output logic TIMER_IN_B,
   output logic STOP_RELEASE_PIN,
   output logic STOP_RELEASE_FALL
);
   import mio_pkg::*;

   mio_state_t st_reg;
   mio_state_t st_next;
   logic [7:0] p0_pin;
   logic [7:0] p1_pin;
   logic [2:0] p2_pin;
   logic [7:0] p0_value;
   logic [7:0] p1_value;
   logic [2:0] p2_en;
   logic [7:0] p0_out_c;
   logic [7:0] p0_oe_c;
   logic [7:0] p1_out_c;
   logic [7:0] p1_oe_c;
   logic [2:0] p2_out_c;
   logic [2:0] p2_oe_c;
   logic [5:0] idx;
   logic req;
   logic ack;
   logic [7:0] p1_view;

   initial
   begin
      if (ADDR_W < 8)
      begin
         $error("mio_ports address must be at least 8 bits");
      end
   end

   mio_sync #(.W(19)) u_sync
   (
      .CLK(CLK),
      .SYS_RST(SYS_RST),
      .d({P2_IN, P1_IN, P0_IN}),
      .q({p2_pin, p1_pin, p0_pin})
   );

   // Bit 2 carries UART transmit, bits 5 and 6 the serial data and clock.
   always_comb
   begin
      p0_value = st_reg.p0_latch;
      p0_value[2] = st_reg.p0_latch[2] & UART_TX_PIN;
      p0_value[5] = st_reg.p0_latch[5] & SERIAL_OUT_PIN;
      p0_value[6] = st_reg.p0_latch[6] & SERIAL_CLOCK_PIN;
   end

   mio_pad_drv #(.W(8)) u_p0_drv
   (
      .value(p0_value),
      .push_pull(st_reg.p0_drv),
      .en(8'hff),
      .out(p0_out_c),
      .oe(p0_oe_c)
   );

   // Timer, divider and pulse outputs reach the pin through the latch.
   assign p1_value = st_reg.p1_latch & P1_FN_OUT;

   mio_pad_drv #(.W(8)) u_p1_drv
   (
      .value(p1_value),
      .push_pull(8'hff),
      .en(st_reg.p1_dir),
      .out(p1_out_c),
      .oe(p1_oe_c)
   );

   // The crystal owns bits 1 and 2 in dual-clock mode; stop mode frees bit 0.
   always_comb
   begin
      p2_en = {3{st_reg.ctrl[`MIO_CTRL_PIN_OUTPUT_ENABLE]}};
      if (st_reg.ctrl[`MIO_CTRL_DUAL])
      begin
         p2_en[2:1] = 2'h0;
      end
      if (st_reg.ctrl[`MIO_CTRL_STOP])
      begin
         p2_en[0] = 1'h0;
      end
   end

   mio_pad_drv #(.W(3)) u_p2_drv
   (
      .value(st_reg.p2_latch),
      .push_pull(3'h0),
      .en(p2_en),
      .out(p2_out_c),
      .oe(p2_oe_c)
   );

   assign idx = AVS_ADDRESS[7:2];
   assign req = AVS_READ | AVS_WRITE;
   assign ack = req & ~st_reg.waitrequest;
   assign p1_view = (st_reg.p1_dir & st_reg.p1_latch) | (~st_reg.p1_dir & p1_pin);

   always_comb
   begin
      st_next = st_reg;
      st_next.waitrequest = ~(req & st_reg.waitrequest);
      // Pins are sampled when the request is first seen.
      if (req & st_reg.waitrequest & AVS_READ)
      begin
         st_next.rdata = 32'h0;
         case (idx)
            `MIO_IDX_P0_LATCH: st_next.rdata[7:0] = st_reg.p0_latch;
            `MIO_IDX_P1_LATCH: st_next.rdata[7:0] = p1_view;
            `MIO_IDX_P2_LATCH: st_next.rdata[2:0] = st_reg.p2_latch;
            `MIO_IDX_P0_DRV: st_next.rdata[7:0] = st_reg.p0_drv;
            `MIO_IDX_P1_DIR: st_next.rdata[7:0] = st_reg.p1_dir;
            `MIO_IDX_P0_PIN: st_next.rdata[7:0] = p0_pin;
            `MIO_IDX_P2_PIN: st_next.rdata[2:0] = p2_pin;
            `MIO_IDX_CTRL: st_next.rdata[2:0] = st_reg.ctrl;
            default: st_next.rdata = 32'h0;
         endcase
      end
      // Writes land at the acknowledge edge; unmapped writes are dropped.
      if (ack & AVS_WRITE)
      begin
         case (idx)
            `MIO_IDX_P0_LATCH: st_next.p0_latch = AVS_WRITEDATA[7:0];
            `MIO_IDX_P1_LATCH: st_next.p1_latch = AVS_WRITEDATA[7:0];
            `MIO_IDX_P2_LATCH: st_next.p2_latch = AVS_WRITEDATA[2:0];
            `MIO_IDX_P0_DRV: st_next.p0_drv = AVS_WRITEDATA[7:0];
            `MIO_IDX_P1_DIR: st_next.p1_dir = AVS_WRITEDATA[7:0];
            `MIO_IDX_CTRL: st_next.ctrl = AVS_WRITEDATA[2:0];
            default: st_next.ctrl = st_reg.ctrl;
         endcase
      end
      st_next.p0_out = p0_out_c;
      st_next.p0_oe = p0_oe_c;
      st_next.p1_out = p1_out_c;
      st_next.p1_oe = p1_oe_c;
      st_next.p2_out = p2_out_c;
      st_next.p2_oe = p2_oe_c;
      st_next.p20_prev = p2_pin[0];
      // A driven falling edge on the pin also flags the interrupt, so inputs are safer.
      st_next.p20_fall = st_reg.p20_prev & ~p2_pin[0];
   end

   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         st_reg <= '0;
         st_reg.p0_latch <= `MIO_RST_P0_LATCH;
         st_reg.p0_drv <= `MIO_RST_P0_DRV;
         st_reg.p1_latch <= `MIO_RST_P1_LATCH;
         st_reg.p1_dir <= `MIO_RST_P1_DIR;
         st_reg.p2_latch <= `MIO_RST_P2_LATCH;
         st_reg.ctrl <= `MIO_RST_CTRL;
         st_reg.waitrequest <= 1'h1;
         // Starts low like the synchroniser, so leaving reset never looks like a falling edge.
         st_reg.p20_prev <= 1'h0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign AVS_READDATA = st_reg.rdata;
   assign AVS_WAITREQUEST = st_reg.waitrequest;
   assign P0_OUT = st_reg.p0_out;
   assign P0_OE = st_reg.p0_oe;
   assign P1_OUT = st_reg.p1_out;
   assign P1_OE = st_reg.p1_oe;
   assign P2_OUT = st_reg.p2_out;
   assign P2_OE = st_reg.p2_oe;
   // Peripheral inputs come straight off the synchroniser's second stage, except the registered stop-pin fall flag.
   assign EXT_IRQ_A = p0_pin[0];
   assign UART_RX_PIN = p0_pin[1];
   assign EXT_IRQ_B = p0_pin[3];
   assign SERIAL_IN_PIN = p0_pin[4];
   assign SERIAL_CLOCK_IN = p0_pin[6];
   assign EXT_IRQ_C = p0_pin[7];
   assign TIMER_IN_A = p1_pin[0];
   assign TIMER_IN_B = p1_pin[5];
   assign EXT_IRQ_D = p1_pin[5];
   assign STOP_RELEASE_PIN = p2_pin[0];
   assign STOP_RELEASE_FALL = st_reg.p20_fall;

   sequence s_first_seen(logic [5:0] i);
      AVS_READ && AVS_WAITREQUEST && idx == i;
   endsequence

   sequence s_answered;
      !AVS_WAITREQUEST;
   endsequence

   property p_reads(logic [5:0] i, logic [31:0] v);
      @(posedge CLK) disable iff (SYS_RST)
      s_first_seen(i) |=> s_answered ##0 AVS_READDATA == v;
   endproperty

   a_reset_p0_values: assert property (@(posedge CLK) SYS_RST |=>
      st_reg.p0_latch == 8'hff && st_reg.p0_drv == 8'h00)
      else $error("port 0 reset values wrong");

   a_open_drain_low: assert property (@(posedge CLK) disable iff (SYS_RST)
      !$past(SYS_RST) |-> (P0_OUT & ~$past(st_reg.p0_drv)) == 8'h00 &&
      (P0_OE & $past(st_reg.p0_drv)) == $past(st_reg.p0_drv))
      else $error("port 0 driver type wrong");

   a_latch_read_back: assert property (p_reads(`MIO_IDX_P0_LATCH, {24'h0, $past(st_reg.p0_latch)}))
      else $error("port 0 latch read wrong");

   a_pin_read_back: assert property (p_reads(`MIO_IDX_P0_PIN, {24'h0, $past(p0_pin)}))
      else $error("port 0 pin read wrong");

   a_uart_tx_gate: assert property (@(posedge CLK) disable iff (SYS_RST)
      !$past(st_reg.p0_latch[2]) && !$past(SYS_RST) |-> !(P0_OUT[2] == 1'h1 || P0_OE[2] == 1'h0))
      else $error("uart output not forced low");

   a_reset_p1_values: assert property (@(posedge CLK) SYS_RST |=>
      st_reg.p1_dir == 8'h00 && st_reg.p1_latch == 8'h00 && st_reg.p2_latch == 3'h7)
      else $error("port 1 or 2 reset values wrong");

   a_p1_mixed_read: assert property (p_reads(`MIO_IDX_P1_LATCH, {24'h0, $past(p1_view)}))
      else $error("port 1 mixed read wrong");

   a_p2_upper_zero: assert property (@(posedge CLK) disable iff (SYS_RST)
      s_first_seen(`MIO_IDX_P2_PIN) |=> AVS_READDATA[31:3] == 29'h0)
      else $error("port 2 upper bits not zero");

   a_p2_stop_float: assert property (@(posedge CLK) disable iff (SYS_RST)
      st_reg.ctrl[`MIO_CTRL_STOP] |=> !P2_OE[0])
      else $error("stop pin still driven");

   a_p2_xtal_free: assert property (@(posedge CLK) disable iff (SYS_RST)
      st_reg.ctrl[`MIO_CTRL_DUAL] |=> P2_OE[2:1] == 2'h0)
      else $error("crystal pins driven");

   a_one_wait_answer: assert property (@(posedge CLK) disable iff (SYS_RST)
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
      else $error("bus answer timing wrong");

   a_fall_pulse: assert property (@(posedge CLK) disable iff (SYS_RST)
      $fell(STOP_RELEASE_PIN) |=> STOP_RELEASE_FALL ##1 !STOP_RELEASE_FALL)
      else $error("stop pin fall not flagged");

   a_no_false_fall: assert property (@(posedge CLK) disable iff (SYS_RST)
      STOP_RELEASE_FALL |-> $past(STOP_RELEASE_PIN, 2) && !$past(STOP_RELEASE_PIN))
      else $error("stop pin fall flagged without a fall");

   a_p2_drive_low: assert property (@(posedge CLK) disable iff (SYS_RST)
      !$past(SYS_RST) && $past(st_reg.ctrl) == `MIO_RST_CTRL |-> P2_OE == ~$past(st_reg.p2_latch))
      else $error("port 2 open-drain drive wrong");

   a_p2_pin_read: assert property (p_reads(`MIO_IDX_P2_PIN, {29'h0, $past(p2_pin)}))
      else $error("port 2 pin read wrong");

   a_p2_latch_read: assert property (p_reads(`MIO_IDX_P2_LATCH, {29'h0, $past(st_reg.p2_latch)}))
      else $error("port 2 latch read wrong");

   a_p1_dir_drive: assert property (@(posedge CLK) disable iff (SYS_RST)
      !$past(SYS_RST) |-> P1_OE == $past(st_reg.p1_dir))
      else $error("port 1 direction not applied");

   a_p1_fn_gate: assert property (@(posedge CLK) disable iff (SYS_RST)
      !$past(SYS_RST) |-> P1_OUT == $past(st_reg.p1_latch & P1_FN_OUT))
      else $error("port 1 function output not gated by latch");

   a_serial_pass: assert property (@(posedge CLK) disable iff (SYS_RST)
      !$past(SYS_RST) && $past(st_reg.p0_drv[5] && st_reg.p0_latch[5]) |->
      P0_OUT[5] == $past(SERIAL_OUT_PIN))
      else $error("serial output not passed through");

   a_sync_delay: assert property (@(posedge CLK) disable iff (SYS_RST)
      !$past(SYS_RST) && !$past(SYS_RST, 2) |-> p0_pin == $past(P0_IN, 2) && p1_pin == $past(P1_IN, 2))
      else $error("pin synchroniser delay wrong");

   a_waitreq_idle: assert property (@(posedge CLK) disable iff (SYS_RST)
      !(AVS_READ || AVS_WRITE) |=> AVS_WAITREQUEST)
      else $error("waitrequest low without a request");

   // A write is checked one edge after its acknowledge, once the register holds it.
   sequence s_write_acked(logic [5:0] i);
      AVS_WRITE && !AVS_WAITREQUEST && idx == i;
   endsequence

   property p_lands(logic [5:0] i, logic [7:0] v);
      @(posedge CLK) disable iff (SYS_RST)
      s_write_acked(i) |=> v == $past(AVS_WRITEDATA[7:0]);
   endproperty

   a_p0_latch_lands: assert property (p_lands(`MIO_IDX_P0_LATCH, st_reg.p0_latch))
      else $error("port 0 latch write lost");

   a_p0_drv_lands: assert property (p_lands(`MIO_IDX_P0_DRV, st_reg.p0_drv))
      else $error("port 0 driver select write lost");

   a_p1_latch_lands: assert property (p_lands(`MIO_IDX_P1_LATCH, st_reg.p1_latch))
      else $error("port 1 latch write lost");

   a_p1_dir_lands: assert property (p_lands(`MIO_IDX_P1_DIR, st_reg.p1_dir))
      else $error("port 1 direction write lost");
endmodule

/* File: hdl/mio_sync.sv */
// Two-stage synchroniser for a vector of pin inputs.
// Assumes the pins carry no edge timing that software relies on.
`timescale 1ns/1ps
module mio_sync
#(
   parameter int W = 8
)
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } mio_sync_t;

   mio_sync_t st_reg;
   mio_sync_t st_next;

   initial
   begin
      if (W < 1)
      begin
         $error("mio_sync width must be at least one");
      end
   end

   always_comb
   begin
      st_next.s1 = d;
      st_next.s2 = st_reg.s1;
   end

   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign q = st_reg.s2;
endmodule

/* File: tb/mio_pin_model.sv */
// Pad model for one port: resolves each pin from the block drive and a bench drive.
// Assumes a pull-up on every pad and that the bench drives only pins the block has released.
`timescale 1ns/1ps
module mio_pin_model
#(
   parameter int W = 8
)
(
   input wire logic [W-1:0] drv_out,
   input wire logic [W-1:0] drv_oe,
   input wire logic [W-1:0] ext_val,
   input wire logic [W-1:0] ext_en,
   output logic [W-1:0] level
);
   // A released pad floats up, so open-drain ones only show as released, never as driven.
   always_comb
   begin
      for (int i = 0; i < W; i++)
      begin
         level[i] = drv_oe[i] ? drv_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
      end
   end
endmodule

/* File: tb/multifunction_io_ports_a_tb.sv */
// Self-checking bench for the three multifunction pin ports.
// Assumes the pad model pulls every released pin high and peripherals idle high.
`timescale 1ns/1ps
`include "mio_params.svh"
module multifunction_io_ports_a_tb;
   logic CLK = 1'b0;
   logic SYS_RST = 1'b1;
   logic [7:0] AVS_ADDRESS = 8'h00;
   logic AVS_READ = 1'b0;
   logic AVS_WRITE = 1'b0;
   logic [31:0] AVS_WRITEDATA = 32'h00000000;
   logic [31:0] AVS_READDATA;
   logic AVS_WAITREQUEST;
   logic [7:0] P0_IN, P0_OUT, P0_OE, P1_IN, P1_OUT, P1_OE;
   logic [2:0] P2_IN, P2_OUT, P2_OE;
   logic UART_TX_PIN = 1'b1;
   logic SERIAL_OUT_PIN = 1'b1;
   logic SERIAL_CLOCK_PIN = 1'b1;
   logic [7:0] P1_FN_OUT = 8'hff;
   logic EXT_IRQ_A, EXT_IRQ_B, EXT_IRQ_C, EXT_IRQ_D, UART_RX_PIN, SERIAL_IN_PIN, SERIAL_CLOCK_IN;
   logic TIMER_IN_A, TIMER_IN_B, STOP_RELEASE_PIN, STOP_RELEASE_FALL;
   logic [7:0] ext0_val = 8'h00, ext0_en = 8'h00, ext1_val = 8'h00, ext1_en = 8'h00;
   logic [2:0] ext2_val = 3'h0, ext2_en = 3'h0;
   int fails = 0;
   int compares = 0;
   int fall_cnt = 0;

   mio_ports u_dut (.CLK(CLK), .SYS_RST(SYS_RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
      .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
      .AVS_WAITREQUEST(AVS_WAITREQUEST), .P0_IN(P0_IN), .P0_OUT(P0_OUT), .P0_OE(P0_OE), .P1_IN(P1_IN),
      .P1_OUT(P1_OUT), .P1_OE(P1_OE), .P2_IN(P2_IN), .P2_OUT(P2_OUT), .P2_OE(P2_OE),
      .UART_TX_PIN(UART_TX_PIN), .SERIAL_OUT_PIN(SERIAL_OUT_PIN), .SERIAL_CLOCK_PIN(SERIAL_CLOCK_PIN),
      .P1_FN_OUT(P1_FN_OUT), .EXT_IRQ_A(EXT_IRQ_A), .EXT_IRQ_B(EXT_IRQ_B), .EXT_IRQ_C(EXT_IRQ_C),
      .EXT_IRQ_D(EXT_IRQ_D), .UART_RX_PIN(UART_RX_PIN), .SERIAL_IN_PIN(SERIAL_IN_PIN),
      .SERIAL_CLOCK_IN(SERIAL_CLOCK_IN), .TIMER_IN_A(TIMER_IN_A), .TIMER_IN_B(TIMER_IN_B),
      .STOP_RELEASE_PIN(STOP_RELEASE_PIN), .STOP_RELEASE_FALL(STOP_RELEASE_FALL));
   mio_pin_model #(.W(8)) u_pin0 (.drv_out(P0_OUT), .drv_oe(P0_OE), .ext_val(ext0_val), .ext_en(ext0_en),
      .level(P0_IN));
   mio_pin_model #(.W(8)) u_pin1 (.drv_out(P1_OUT), .drv_oe(P1_OE), .ext_val(ext1_val), .ext_en(ext1_en),
      .level(P1_IN));
   mio_pin_model #(.W(3)) u_pin2 (.drv_out(P2_OUT), .drv_oe(P2_OE), .ext_val(ext2_val), .ext_en(ext2_en),
      .level(P2_IN));

   always #50 CLK = ~CLK;

   always @(posedge CLK)
   begin
      if (STOP_RELEASE_FALL === 1'b1)
         fall_cnt <= fall_cnt + 1;
   end

   task automatic finish_test;
      $display("comparisons %0d, mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // The request is held until waitrequest is sampled low; a slave that never answers ends the run.
   task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] d, output logic [31:0] q);
      int n;
      @(posedge CLK);
      AVS_ADDRESS <= {idx, 2'b00};
      AVS_WRITEDATA <= {24'h000000, d};
      AVS_WRITE <= wr;
      AVS_READ <= ~wr;
      n = 0;
      do
      begin
         @(posedge CLK);
         n++;
      end
      while (AVS_WAITREQUEST !== 1'b0 && n < 20);
      q = AVS_READDATA;
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
      if (AVS_WAITREQUEST !== 1'b0)
      begin
         fails++;
         finish_test();
      end
   endtask

   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, idx, d, q);
   endtask

   task automatic rdc(input logic [5:0] idx, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, idx, 8'h00, q);
      check(q, exp);
   endtask

   task automatic test_reset;
      check({P0_OE, P1_OE, 5'h00, P2_OE}, 32'h0);
      rdc(`MIO_IDX_P0_LATCH, 32'hff);
      rdc(`MIO_IDX_P0_DRV, 32'h00);
      rdc(`MIO_IDX_P1_DIR, 32'h00);
      rdc(`MIO_IDX_P2_LATCH, 32'h7);
      rdc(6'h3f, 32'h0);
      wr(`MIO_IDX_P1_DIR, 8'hff);
      rdc(`MIO_IDX_P1_LATCH, 32'h00);
      wr(`MIO_IDX_P1_DIR, 8'h00);
      check(fall_cnt, 32'h0);
      $display("test_reset done");
   endtask

   task automatic test_p0_pins;
      logic [7:0] p;
      for (int k = 0; k < 2; k++)
      begin
         p = k ? 8'hc3 : 8'h3c;
         ext0_en <= 8'hff;
         ext0_val <= p;
         repeat (2) @(posedge CLK);
         check(EXT_IRQ_A, !p[0]);
         @(posedge CLK);
         check(EXT_IRQ_A, p[0]);
         check({EXT_IRQ_C, SERIAL_CLOCK_IN, SERIAL_IN_PIN, EXT_IRQ_B, UART_RX_PIN}, {p[7:6], p[4:3], p[1]});
         rdc(`MIO_IDX_P0_PIN, p);
         rdc(`MIO_IDX_P0_LATCH, 32'hff);
      end
      ext0_en <= 8'h00;
      $display("test_p0_pins done");
   endtask

   task automatic test_p0_drive;
      wr(`MIO_IDX_P0_LATCH, 8'h5a);
      wr(`MIO_IDX_P0_DRV, 8'hf0);
      repeat (2) @(posedge CLK);
      check(P0_OE, {8'hf0 | ~8'h5a});
      check(P0_OUT & P0_OE, 8'h5a & 8'hf0);
      wr(`MIO_IDX_P0_LATCH, 8'hff);
      wr(`MIO_IDX_P0_DRV, 8'hff);
      {UART_TX_PIN, SERIAL_OUT_PIN, SERIAL_CLOCK_PIN} <= 3'h0;
      repeat (3) @(posedge CLK);
      check(P0_OUT, 8'h9b);
      {UART_TX_PIN, SERIAL_OUT_PIN, SERIAL_CLOCK_PIN} <= 3'h7;
      repeat (3) @(posedge CLK);
      check(P0_OUT, 8'hff);
      wr(`MIO_IDX_P0_LATCH, 8'h9b);
      repeat (2) @(posedge CLK);
      check(P0_OUT, 8'h9b);
      wr(`MIO_IDX_P0_LATCH, 8'hff);
      wr(`MIO_IDX_P0_DRV, 8'h00);
      $display("test_p0_drive done");
   endtask

   // Bits 0 and 5 stay inputs so the read-modify-write has a pin value to copy into the latch.
   task automatic test_p1;
      logic [31:0] q;
      wr(`MIO_IDX_P1_LATCH, 8'ha5);
      wr(`MIO_IDX_P1_DIR, 8'hde);
      ext1_en <= 8'h21;
      ext1_val <= 8'h20;
      P1_FN_OUT <= 8'hfb;
      repeat (4) @(posedge CLK);
      check(P1_OE, 8'hde);
      check(P1_OUT & P1_OE, 8'ha5 & 8'hfb & 8'hde);
      check({TIMER_IN_A, TIMER_IN_B, EXT_IRQ_D}, 3'b011);
      bus(1'b0, `MIO_IDX_P1_LATCH, 8'h00, q);
      check(q, (8'ha5 & 8'hde) | (8'h20 & 8'h21));
      wr(`MIO_IDX_P1_LATCH, q[7:0]);
      ext1_en <= 8'h00;
      P1_FN_OUT <= 8'hff;
      wr(`MIO_IDX_P1_DIR, 8'hff);
      rdc(`MIO_IDX_P1_LATCH, 32'ha4);
      wr(`MIO_IDX_P1_DIR, 8'h00);
      $display("test_p1 done");
   endtask

   task automatic test_p2;
      int n0;
      n0 = fall_cnt;
      rdc(`MIO_IDX_CTRL, 32'h4);
      wr(`MIO_IDX_P2_LATCH, 8'h06);
      repeat (8) @(posedge CLK);
      check(P2_OE, 3'b001);
      check(fall_cnt - n0, 32'h1);
      check(P2_OUT, 3'h0);
      check(STOP_RELEASE_PIN, 1'b0);
      rdc(`MIO_IDX_P2_PIN, 32'h6);
      rdc(`MIO_IDX_P2_LATCH, 32'h6);
      wr(`MIO_IDX_CTRL, 8'h06);
      repeat (2) @(posedge CLK);
      check(P2_OE, 3'b000);
      wr(`MIO_IDX_P2_LATCH, 8'h01);
      wr(`MIO_IDX_CTRL, 8'h04);
      repeat (2) @(posedge CLK);
      check(P2_OE, 3'b110);
      wr(`MIO_IDX_CTRL, 8'h05);
      repeat (2) @(posedge CLK);
      check(P2_OE[2:1], 2'b00);
      wr(`MIO_IDX_P2_LATCH, 8'h07);
      wr(`MIO_IDX_CTRL, 8'h04);
      $display("test_p2 done");
   endtask

   initial
   begin
      repeat (5) @(posedge CLK);
      SYS_RST <= 1'b0;
      test_reset();
      test_p0_pins();
      test_p0_drive();
      test_p1();
      test_p2();
      finish_test();
   end
endmodule
